/* File: src/umspi_map.vh */
// register map, field positions, reset values and constants of the master spi serial port
`ifndef UMSPI_MAP_VH
`define UMSPI_MAP_VH

// apb byte addresses
`define UMSPI_ADDR_DATA      12'h000
`define UMSPI_ADDR_STATUS_A  12'h004
`define UMSPI_ADDR_CONTROL_B 12'h008
`define UMSPI_ADDR_FORMAT_C  12'h00C
`define UMSPI_ADDR_BAUD      12'h010
`define UMSPI_ADDR_IRQ       12'h014

// status a fields
`define UMSPI_A_RXC          7
`define UMSPI_A_TXC          6
`define UMSPI_A_UDRE         5
// control b fields
`define UMSPI_B_RXCIE        7
`define UMSPI_B_TXCIE        6
`define UMSPI_B_TX_EMPTY_IRQ_ENABLE        5
`define UMSPI_B_RXEN         4
`define UMSPI_B_TXEN         3
// format c fields
`define UMSPI_C_MSEL_HI      7
`define UMSPI_C_MSEL_LO      6
`define UMSPI_C_ORDER        2
`define UMSPI_C_PHASE        1
`define UMSPI_C_POL          0
`define UMSPI_MODE_SPI       2'b11

// reset values
`define UMSPI_RST_CONTROL_B  8'h00
`define UMSPI_RST_FORMAT_C   8'h06
`define UMSPI_RST_BAUD       12'h000

// frame and buffer sizes
`define UMSPI_FRAME_BITS     8
`define UMSPI_RX_DEPTH       2

`endif

/* File: src/umspi_rx_mem.v */
// two-entry receive buffer memory with registered read data
`timescale 1ns/10ps
`default_nettype none

module umspi_rx_mem #(
    parameter WIDTH = 8,
    parameter AW    = 1
) (
    input  wire             pclk,    // system clock
    input  wire             we,      // write strobe
    input  wire [AW-1:0]    waddr,   // write slot
    input  wire [WIDTH-1:0] wdata,   // write data
    input  wire [AW-1:0]    raddr,   // read slot
    output reg  [WIDTH-1:0] rdata_q  // registered read data
);

    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    // storage has no reset; the pointers decide what is valid
    always @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end

endmodule
`default_nettype wire

/* File: src/umspi_top.v */
// master-only spi serial port with apb register access
`timescale 1ns/10ps
`default_nettype none
`include "umspi_map.vh"

module umspi_top #(
    parameter BAUD_W = 12
) (
    input  wire        pclk,          // system clock
    input  wire        presetn,       // async reset, active low
    input  wire        psel,          // apb select
    input  wire        penable,       // apb access phase
    input  wire        pwrite,        // apb write
    input  wire [11:0] paddr,         // apb byte address
    input  wire [31:0] pwdata,        // apb write data
    output wire [31:0] prdata,        // apb read data
    output wire        pready,        // apb ready, always one
    output wire        pslverr,       // apb error on unmapped address
    input  wire        global_irq_en, // processor global interrupt flag
    input  wire        txc_irq_ack,   // transmit-complete interrupt executed
    output wire        rxc_irq,       // receive-complete interrupt request
    output wire        txc_irq,       // transmit-complete interrupt request
    output wire        udre_irq,      // buffer-empty interrupt request
    output reg         xck_q,         // transfer clock pin (sck)
    output reg         txd_q,         // transmit data pin (mosi)
    output wire        txd_oe,        // tx pin overridden by transmitter
    input  wire        rxd_in,        // receive data pin (miso)
    output wire        rxd_override   // rx pin taken as serial input
);

    localparam ST_IDLE  = 3'b001;
    localparam ST_FIRST = 3'b010;
    localparam ST_LAST  = 3'b100;

    // decode a write to a given register
    function wr_hit;
        input [11:0] addr;
        input [11:0] target;
        begin
            wr_hit = psel & penable & pwrite & (addr == target);
        end
    endfunction

    reg  [7:0]        ctl_q;
    reg  [7:0]        fmt_q;
    reg  [BAUD_W-1:0] baud_q;
    reg               txc_q;
    reg  [7:0]        tbuf_q;
    reg               tbuf_full_q;
    reg  [2:0]        st_q;
    reg  [BAUD_W-1:0] div_q;
    reg  [7:0]        tsh_q;
    reg  [7:0]        rsh_q;
    reg  [2:0]        bit_q;
    reg               txen_q;
    reg  [1:0]        rcnt_q;
    reg               wptr_q;
    reg               rptr_q;
    reg  [31:0]       rdata_r;

    wire        spi_mode   = (fmt_q[`UMSPI_C_MSEL_HI:`UMSPI_C_MSEL_LO] == `UMSPI_MODE_SPI);
    wire        lsb_first  = fmt_q[`UMSPI_C_ORDER];
    wire        cpha       = fmt_q[`UMSPI_C_PHASE];
    wire        cpol       = fmt_q[`UMSPI_C_POL];
    wire        rxen       = ctl_q[`UMSPI_B_RXEN];
    wire        wr_data    = wr_hit(paddr, `UMSPI_ADDR_DATA);
    wire        wr_a       = wr_hit(paddr, `UMSPI_ADDR_STATUS_A);
    wire        rd_data    = psel & penable & ~pwrite & (paddr == `UMSPI_ADDR_DATA);
    wire        udre       = ~tbuf_full_q;
    wire        rxc        = (rcnt_q != 2'd0);
    wire        div_tick   = (div_q == {BAUD_W{1'b0}});
    wire        busy       = (st_q != ST_IDLE);
    wire        shift_done = (st_q == ST_LAST) & div_tick & (bit_q == 3'd7);
    wire        load       = tbuf_full_q & txen_q & spi_mode & (~busy | shift_done);
    wire        tx_out_bit = lsb_first ? tsh_q[0] : tsh_q[7];
    wire        rx_push    = shift_done & rxen;
    wire        mapped     = (paddr == `UMSPI_ADDR_DATA) | (paddr == `UMSPI_ADDR_STATUS_A) |
                             (paddr == `UMSPI_ADDR_CONTROL_B) | (paddr == `UMSPI_ADDR_FORMAT_C) |
                             (paddr == `UMSPI_ADDR_BAUD) | (paddr == `UMSPI_ADDR_IRQ);
    wire [7:0]  rx_word;
    wire [7:0]  rx_next    = lsb_first ? {rxd_in, rsh_q[7:1]} : {rsh_q[6:0], rxd_in};

    // apb: zero wait states, error only on an unmapped address
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = rdata_r;

    // interrupt requests gated by enable, global flag and the flag itself
    assign rxc_irq  = ctl_q[`UMSPI_B_RXCIE] & global_irq_en & rxc;
    assign txc_irq  = ctl_q[`UMSPI_B_TXCIE] & global_irq_en & txc_q;
    assign udre_irq = ctl_q[`UMSPI_B_TX_EMPTY_IRQ_ENABLE] & global_irq_en & udre;

    // pin overrides
    assign txd_oe       = txen_q;
    assign rxd_override = rxen;

    // read mux; error flags 4:0 of status a are never driven, so read zero
    always @* begin
        case (paddr)
            `UMSPI_ADDR_DATA:      rdata_r = {24'h00_0000, rx_word};
            `UMSPI_ADDR_STATUS_A:  rdata_r = {24'h00_0000, rxc, txc_q, udre, 5'b0_0000};
            `UMSPI_ADDR_CONTROL_B: rdata_r = {24'h00_0000, ctl_q[7:3], 3'b000};
            `UMSPI_ADDR_FORMAT_C:  rdata_r = {24'h00_0000, fmt_q[7:6], 3'b000, fmt_q[2:0]};
            `UMSPI_ADDR_BAUD:      rdata_r = {{(32-BAUD_W){1'b0}}, baud_q};
            `UMSPI_ADDR_IRQ:       rdata_r = {29'h0000_0000, udre_irq, txc_irq, rxc_irq};
            default:               rdata_r = 32'h0000_0000;
        endcase
    end

    // control, format and baud registers; reserved bits are masked off
    // so that a careless write of ones there changes nothing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q  <= `UMSPI_RST_CONTROL_B;
            fmt_q  <= `UMSPI_RST_FORMAT_C;
            baud_q <= `UMSPI_RST_BAUD;
        end else begin
            if (wr_hit(paddr, `UMSPI_ADDR_CONTROL_B)) begin
                ctl_q <= {pwdata[7:3], 3'b000};
            end
            if (wr_hit(paddr, `UMSPI_ADDR_FORMAT_C)) begin
                // mode and frame settings land in one write
                fmt_q <= {pwdata[7:6], 3'b000, pwdata[2:0]};
            end
            if (wr_hit(paddr, `UMSPI_ADDR_BAUD)) begin
                baud_q <= pwdata[BAUD_W-1:0];
            end
        end
    end

    // transmitter enable: a clear only lands once shifter and buffer are empty
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txen_q <= 1'b0;
        end else if (ctl_q[`UMSPI_B_TXEN]) begin
            txen_q <= 1'b1;
        end else if (!busy && !tbuf_full_q) begin
            txen_q <= 1'b0;
        end
    end

    // transmit buffer; a write while full is dropped, software must poll udre
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbuf_q      <= 8'h00;
            tbuf_full_q <= 1'b0;
        end else if (wr_data && !tbuf_full_q) begin
            tbuf_q      <= pwdata[7:0];
            tbuf_full_q <= 1'b1;
        end else if (load) begin
            tbuf_full_q <= 1'b0;
        end
    end

    // transmit complete: the set wins over a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txc_q <= 1'b0;
        end else if (shift_done && !tbuf_full_q) begin
            txc_q <= 1'b1;
        end else if (txc_irq_ack || (wr_a && pwdata[`UMSPI_A_TXC])) begin
            txc_q <= 1'b0;
        end
    end

    // shift engine: each bit takes two half periods of (baud+1) cycles
    // first half ends on the leading edge, second on the trailing edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= ST_IDLE;
            div_q <= {BAUD_W{1'b0}};
            tsh_q <= 8'h00;
            rsh_q <= 8'h00;
            bit_q <= 3'd0;
            xck_q <= 1'b0;
            txd_q <= 1'b1;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    xck_q <= cpol;
                    txd_q <= 1'b1;
                    if (load) begin
                        // only the transmitter starts frames; rx alone idles
                        st_q  <= ST_FIRST;
                        div_q <= baud_q;
                        tsh_q <= tbuf_q;
                        bit_q <= 3'd0;
                        if (!cpha) begin
                            txd_q <= lsb_first ? tbuf_q[0] : tbuf_q[7];
                        end
                    end
                end
                ST_FIRST: begin
                    if (div_tick) begin
                        div_q <= baud_q;
                        xck_q <= ~cpol;
                        st_q  <= ST_LAST;
                        if (cpha) begin
                            txd_q <= tx_out_bit;
                        end else begin
                            rsh_q <= rx_next;
                        end
                    end else begin
                        div_q <= div_q - 1'b1;
                    end
                end
                ST_LAST: begin
                    if (div_tick) begin
                        div_q <= baud_q;
                        xck_q <= cpol;
                        if (cpha) begin
                            rsh_q <= rx_next;
                        end
                        bit_q <= bit_q + 3'd1;
                        if (bit_q == 3'd7) begin
                            // eight bits per frame; chain straight on if loaded
                            if (load) begin
                                st_q  <= ST_FIRST;
                                tsh_q <= tbuf_q;
                                if (!cpha) begin
                                    txd_q <= lsb_first ? tbuf_q[0] : tbuf_q[7];
                                end
                            end else begin
                                st_q <= ST_IDLE;
                            end
                        end else begin
                            st_q  <= ST_FIRST;
                            tsh_q <= lsb_first ? {1'b0, tsh_q[7:1]} : {tsh_q[6:0], 1'b0};
                            if (!cpha) begin
                                txd_q <= lsb_first ? tsh_q[1] : tsh_q[6];
                            end
                        end
                    end else begin
                        div_q <= div_q - 1'b1;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // receive buffer pointers; the captured byte uses the final sample,
    // so push the assembled value including the last bit when cpha=1
    wire [7:0] rx_final = cpha ? rx_next : rsh_q;
    wire       rx_full  = (rcnt_q == `UMSPI_RX_DEPTH);
    wire       rx_pop   = rd_data & rxc;
    wire       rx_wr    = rx_push & ~rx_full;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcnt_q <= 2'd0;
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
        end else if (!rxen) begin
            // receiver off: flush everything
            rcnt_q <= 2'd0;
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
        end else begin
            if (rx_wr) begin
                wptr_q <= ~wptr_q;
            end
            if (rx_pop) begin
                rptr_q <= ~rptr_q;
            end
            case ({rx_wr, rx_pop})
                2'b10:   rcnt_q <= rcnt_q + 2'd1;
                2'b01:   rcnt_q <= rcnt_q - 2'd1;
                default: rcnt_q <= rcnt_q;
            endcase
        end
    end

    // memory read data looks ahead on a pop and follows the read pointer in the same cycle, so the
    // head entry is always ready before the next apb access phase
    umspi_rx_mem #(
        .WIDTH (8),
        .AW    (1)
    ) u_rx_mem (
        .pclk    (pclk),
        .we      (rx_wr),
        .waddr   (wptr_q),
        .wdata   (rx_final),
        .raddr   (rx_pop ? ~rptr_q : rptr_q),
        .rdata_q (rx_word)
    );

endmodule
`default_nettype wire

/* File: tb/umspi_monitor.sv */
// port-level assertions for the master spi serial port
`timescale 1ns/10ps
`default_nettype none
module umspi_monitor (
    input wire logic        pclk,          // clock
    input wire logic        presetn,       // reset, low
    input wire logic        psel,          // apb select
    input wire logic        penable,       // apb access
    input wire logic        pwrite,        // apb write
    input wire logic [11:0] paddr,         // apb address
    input wire logic [31:0] pwdata,        // write data
    input wire logic [31:0] prdata,        // read data
    input wire logic        global_irq_en, // global flag
    input wire logic        txc_irq_ack,   // tx irq taken
    input wire logic        rxc_irq,       // rx request
    input wire logic        txc_irq,       // tx request
    input wire logic        udre_irq,      // empty request
    input wire logic        xck_q,         // serial clock
    input wire logic        txd_oe,        // tx pin owned
    input wire logic        rxd_override   // rx pin owned
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // one finished apb transfer to a given address
    sequence s_acc(logic w, logic [11:0] a);
        psel && penable && pwrite == w && paddr == a;
    endsequence
    // transmitter off and no format write, so the clock pin has no reason to move
    sequence s_quiet;
        (!txd_oe && !(psel && penable && pwrite && paddr == 12'h00C))[*2];
    endsequence
    chk_rxc_irq_gate: assert property (rxc_irq |-> global_irq_en)
        else $error("rx irq without global flag");
    chk_txc_irq_gate: assert property (txc_irq |-> global_irq_en)
        else $error("tx irq without global flag");
    chk_udre_irq_gate: assert property (udre_irq |-> global_irq_en)
        else $error("empty irq without global flag");
    chk_err_flags_zero: assert property (s_acc(1'b0, 12'h004) |-> prdata[4:0] == 5'h00)
        else $error("error flags not zero");
    chk_rxc_flag_view: assert property (s_acc(1'b0, 12'h004) ##0 rxc_irq |-> prdata[7])
        else $error("rx irq but flag clear");
    chk_sck_idle_hold: assert property (s_quiet |=> $stable(xck_q))
        else $error("clock moved while idle");
    chk_rxen_follow: assert property (s_acc(1'b1, 12'h008) |=> rxd_override == $past(pwdata[4]))
        else $error("rx pin override wrong");
    chk_txen_take: assert property (s_acc(1'b1, 12'h008) ##0 pwdata[3] |-> ##2 txd_oe)
        else $error("tx pin not taken");
    chk_txc_clear: assert property (txc_irq_ack or s_acc(1'b1, 12'h004) ##0 pwdata[6] |=> !txc_irq)
        else $error("tx complete not cleared");
endmodule
bind umspi_top umspi_monitor i_umspi_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .global_irq_en, .txc_irq_ack, .rxc_irq, .txc_irq, .udre_irq,
    .xck_q, .txd_oe, .rxd_override);
`default_nettype wire

/* File: tb/umspi_slave_model.sv */
// spi slave model: replies with the previous byte received, scrambled
`timescale 1ns/10ps
`default_nettype none
module umspi_slave_model (
    input  wire logic       xck,  // serial clock
    input  wire logic       mosi, // master out
    input  wire logic       en,   // master transmitting
    input  wire logic       cpol, // idle clock level
    input  wire logic       cpha, // trailing-edge sampling
    input  wire logic       lsb,  // lsb first
    output var  logic       miso, // master in
    output var  logic [7:0] got,  // last byte
    output var  int         cnt   // frames seen
);
    logic [7:0] sh  = 8'h00;
    logic [7:0] nxt = 8'h3C;
    int         ns  = 0;
    initial begin
        miso = 1'b0;
        got = 8'h00;
        cnt = 0;
    end
    function automatic logic pick(input int k);
        pick = lsb ? nxt[k] : nxt[7 - k];
    endfunction
    // leading-edge sampling needs the first bit on the line before any edge
    always @(posedge en) begin
        if (!cpha) begin
            miso = pick(0);
        end
    end
    // the setup edge drives a reply bit, the other edge takes the master's bit
    always @(xck) begin
        if (en && ((xck !== cpol) == cpha)) begin
            miso = pick(ns);
        end else if (en) begin
            sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
            ns++;
            if (ns == 8) begin
                ns = 0;
                got = sh;
                cnt++;
                nxt = sh ^ 8'hA5;
                miso = ~miso; // no stale level between frames
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/umspi_tb.sv */
// self-checking bench: apb driver, slave model and reference queue
`timescale 1ns/10ps
`default_nettype none
`include "umspi_map.vh"
module umspi_tb;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic        gie     = 1'b0;
    logic        ack     = 1'b0;
    logic        mcpol   = 1'b0;
    logic        mcpha   = 1'b0;
    logic        mlsb    = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] seed    = 32'h6a86_24a2;
    logic [31:0] prdata;
    logic        pready, pslverr, rxc_i, txc_i, udre_i, xck, txd, txd_oe, rxo, miso, e;
    logic [7:0]  s, d, got;
    logic [7:0]  rep = 8'h3C;
    logic [7:0]  q[$];
    int          errors = 0;
    int          n_tests = 0;
    int          cnt, m, k;
    umspi_top i_umspi_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .global_irq_en(gie), .txc_irq_ack(ack),
        .rxc_irq(rxc_i), .txc_irq(txc_i), .udre_irq(udre_i), .xck_q(xck), .txd_q(txd),
        .txd_oe, .rxd_in(miso), .rxd_override(rxo));
    umspi_slave_model i_umspi_slave_model (.xck, .mosi(txd), .en(txd_oe), .cpol(mcpol),
        .cpha(mcpha), .lsb(mlsb), .miso, .got, .cnt);
    // 50 MHz clock
    initial begin
        forever #10 pclk = ~pclk;
    end
    // a hung wait ends the run as a failure
    initial begin
        #1_000_000;
        errors++;
        complete_run();
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        rnd = seed;
    endfunction
    task automatic complete_run();
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    // setup cycle, then access until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        logic rdy;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        // read mid-cycle what the next rising edge will see; sampling right at
        // the edge would race the registers that the same edge updates
        do begin
            @(negedge pclk);
            rdy = pready;
            s = prdata[7:0];
            e = pslverr;
            @(posedge pclk);
        end while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        apb(1'b1, a, {24'h00_0000, v});
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic poll(input int b);
        do rd(`UMSPI_ADDR_STATUS_A); while (s[b] !== 1'b1);
    endtask
    // reset values, then four clock modes with overflow and deferred disable
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`UMSPI_ADDR_STATUS_A);
        chk("status_rst", 8'h20, s);
        rd(`UMSPI_ADDR_CONTROL_B);
        chk("control_rst", 8'h00, s);
        rd(`UMSPI_ADDR_FORMAT_C);
        chk("format_rst", 8'h06, s);
        rd(12'h018);
        chk("unmapped", 8'h01, {7'h00, e});
        for (m = 0; m < 4; m++) begin
            mcpol = m[1];
            mcpha = m[0];
            mlsb = m[1] ^ m[0];
            gie <= m[1];
            d = rnd();
            wr(`UMSPI_ADDR_FORMAT_C, {5'h18, mlsb, mcpha, mcpol});
            wr(`UMSPI_ADDR_BAUD, {6'h00, d[1:0]});
            wr(`UMSPI_ADDR_CONTROL_B, 8'hF8);
            if (m[0]) begin
                @(posedge pclk);
                ack <= 1'b1;
                @(posedge pclk);
                ack <= 1'b0;
            end else begin
                wr(`UMSPI_ADDR_STATUS_A, 8'h40);
            end
            rd(`UMSPI_ADDR_STATUS_A);
            chk("txc_clear", 8'h20, s);
            for (k = 0; k < 3; k++) begin
                poll(`UMSPI_A_UDRE);
                d = rnd();
                wr(`UMSPI_ADDR_DATA, d);
                q.push_back(rep);
                rep = d ^ 8'hA5;
            end
            wr(`UMSPI_ADDR_CONTROL_B, 8'hF0);
            poll(`UMSPI_A_TXC);
            rd(`UMSPI_ADDR_STATUS_A);
            chk("status_done", 8'hE0, s);
            chk("tx_release", 8'h00, {7'h00, txd_oe});
            rd(`UMSPI_ADDR_IRQ);
            chk("irq_view", m[1] ? 8'h07 : 8'h00, s);
            chk("slave_last", d, got);
            chk("slave_count", 8'(3 * m + 3), cnt[7:0]);
            for (k = 0; k < 2; k++) begin
                rd(`UMSPI_ADDR_DATA);
                chk("rx_data", q[k], s);
            end
            rd(`UMSPI_ADDR_STATUS_A);
            chk("rx_empty", 8'h60, s);
            q.delete();
        end
        wr(`UMSPI_ADDR_STATUS_A, 8'h40);
        wr(`UMSPI_ADDR_CONTROL_B, 8'h18);
        wr(`UMSPI_ADDR_DATA, 8'h5A);
        poll(`UMSPI_A_RXC);
        wr(`UMSPI_ADDR_CONTROL_B, 8'h08);
        rd(`UMSPI_ADDR_STATUS_A);
        chk("rx_flush", 8'h60, s);
        wr(`UMSPI_ADDR_CONTROL_B, 8'h10);
        wr(`UMSPI_ADDR_DATA, 8'hC3);
        repeat (80) @(posedge pclk);
        chk("rx_only_count", 8'h0D, cnt[7:0]);
        rd(`UMSPI_ADDR_STATUS_A);
        chk("rx_only_status", 8'h40, s);
        complete_run();
    end
endmodule
`default_nettype wire
